// ---- inc/csx_map.vh ----
// Constants for the system-control executor: encodings, register map and field positions.
`ifndef CSX_MAP_VH
`define CSX_MAP_VH
// Register word offsets on the plain register port.
`define CSX_REG_FLAGS 3'h0
`define CSX_REG_COUNT 3'h1
`define CSX_REG_SRC 3'h2
`define CSX_REG_DST 3'h3
`define CSX_REG_STATUS 3'h4
// Reset values.
`define CSX_FLAGS_RST 8'h80
`define CSX_COUNT_RST 16'h0000
`define CSX_PTR_RST 32'h00000000
// Instruction word fields.
`define CSX_F_OP 15:12
`define CSX_F_SUB 11:8
`define CSX_F_CC 11:8
`define CSX_F_AREG 6:4
`define CSX_F_DREG 3:0
`define CSX_F_BITNO 6:4
`define CSX_F_TRAP 5:4
`define CSX_F_IMM 7:0
// Primary function codes.
`define CSX_OP_SYS 4'h0
`define CSX_OP_BRANCH 4'h4
`define CSX_OP_BIT 4'h7
// System group second function codes.
`define CSX_SYS_NOP 4'h0
`define CSX_SYS_SLEEP 4'h1
`define CSX_SYS_RTE 4'h2
`define CSX_SYS_TRAP 4'h3
`define CSX_SYS_AND_FLAGS_IMM 4'h4
`define CSX_SYS_ORC 4'h5
`define CSX_SYS_XOR_FLAGS_IMM 4'h6
`define CSX_SYS_LDF 4'h7
`define CSX_SYS_STF 4'h8
`define CSX_SYS_BMB 4'h9
`define CSX_SYS_BMW 4'ha
// Bit group second function codes.
`define CSX_BIT_SET 4'h0
`define CSX_BIT_CLR 4'h1
`define CSX_BIT_NOT 4'h2
`define CSX_BIT_ST 4'h3
`define CSX_BIT_IST 4'h4
// Flag bit positions.
`define CSX_FL_C 0
`define CSX_FL_V 1
`define CSX_FL_Z 2
`define CSX_FL_N 3
// Instruction lengths in bytes.
`define CSX_LEN_SHORT 4'h2
`define CSX_LEN_EXT 4'h6
`endif

// ---- rtl/csx_exec.v ----
// System-control, block-move and bit read-modify-write executor with its decoder.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
//
// Notes on behaviour
// - Software trap instruction starts trap exception processing.
// - Trap carries a two-bit field choosing the vector address.
// - Exception return leaves the handler and resumes the interrupted flow.
// - Sleep instruction enters the power-down state.
// - Loading the flags register from memory uses a word read.
// - Storing the flags register to memory uses a word write.
// - AND immediate replaces flags with flags AND 8-bit immediate.
// - OR immediate replaces flags with flags OR immediate.
// - XOR immediate replaces flags with flags XOR immediate.
// - No-operation only advances the program counter by two.
// - Block move uses count, source and destination; 8-bit or 16-bit count.
// - Count is bytes; zero moves nothing, else copy and decrement until zero.
// - Each byte access adds one to the 32-bit pointer.
// - Next instruction waits until the whole block transfer has finished.
// - Instructions are whole numbers of 16-bit words.
// - Function code sits in the top four bits of the first word.
// - Address registers use 3-bit codes, data registers 3 or 4 bits.
// - Extension is 8, 16 or 32 bits of data, address or displacement.
// - A 24-bit address occupies 32 bits with upper byte zero.
// - Branches carry a condition field selecting the tested condition.
// - Bit set, clear, invert and carry stores read, modify, write a byte.
`include "csx_map.vh"

module csx_exec #(
	parameter CNT_W = 16,
	parameter PTR_W = 32
) (
	input wire sys_clk,
	input wire rst_n,
	input wire ins_valid,
	output wire ins_ready,
	input wire [15:0] ins_word,
	input wire [31:0] ins_ext,
	output reg pc_adv,
	output reg [3:0] pc_step,
	output reg trap_start,
	output reg [1:0] trap_vector,
	output reg rte_start,
	output reg sleep_mode,
	input wire wake_pin,
	output reg branch_taken,
	output reg [7:0] branch_disp,
	output reg [2:0] addr_reg_sel,
	output reg [3:0] data_reg_sel,
	output reg mem_req,
	output reg mem_we,
	output reg mem_word,
	output reg [23:0] mem_addr,
	output reg [15:0] mem_wdata,
	input wire [15:0] mem_rdata,
	input wire mem_ack,
	input wire [2:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output wire [7:0] condition_flags_reg,
	output wire busy
);

	// =========================================================
	// States
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_LDF = 3'h1;
	localparam [2:0] ST_STF = 3'h2;
	localparam [2:0] ST_BM_RD = 3'h3;
	localparam [2:0] ST_BM_WR = 3'h4;
	localparam [2:0] ST_RMW_RD = 3'h5;
	localparam [2:0] ST_RMW_WR = 3'h6;

	reg [2:0] state;
	reg [7:0] flags;
	reg [CNT_W-1:0] count;
	reg [PTR_W-1:0] src_ptr;
	reg [PTR_W-1:0] dst_ptr;
	reg bm_byte;
	reg [3:0] bit_sub;
	reg [2:0] bit_no;
	reg wake_meta;
	reg wake_sync;

	assign condition_flags_reg = flags;
	assign busy = (state != ST_IDLE);
	// The next instruction is only taken once the executor is idle and awake.
	assign ins_ready = (state == ST_IDLE) && !sleep_mode;

	wire take = ins_valid && ins_ready;
	wire [3:0] op = ins_word[`CSX_F_OP];
	wire [3:0] sub = ins_word[`CSX_F_SUB];
	wire [7:0] imm = ins_word[`CSX_F_IMM];

	// =========================================================
	// Functions
	// A 24-bit address is carried in a 32-bit field whose top byte is zero.
	function [23:0] ext_addr;
		input [31:0] ext;
		begin
			ext_addr = ext[23:0];
		end
	endfunction

	// Length is counted in bytes: one word, or one word and a 32-bit extension.
	function [3:0] ins_len;
		input [3:0] f_op;
		input [3:0] f_sub;
		begin
			if (f_op == `CSX_OP_BIT)
				ins_len = `CSX_LEN_EXT;
			else if (f_op == `CSX_OP_SYS &&
				(f_sub == `CSX_SYS_LDF || f_sub == `CSX_SYS_STF))
				ins_len = `CSX_LEN_EXT;
			else
				ins_len = `CSX_LEN_SHORT;
		end
	endfunction

	function cond_true;
		input [3:0] cc;
		input [7:0] f;
		reg c;
		reg v;
		reg z;
		reg n;
		begin
			c = f[`CSX_FL_C];
			v = f[`CSX_FL_V];
			z = f[`CSX_FL_Z];
			n = f[`CSX_FL_N];
			case (cc)
				4'h0: cond_true = 1'b1;
				4'h1: cond_true = 1'b0;
				4'h2: cond_true = !(c | z);
				4'h3: cond_true = c | z;
				4'h4: cond_true = !c;
				4'h5: cond_true = c;
				4'h6: cond_true = !z;
				4'h7: cond_true = z;
				4'h8: cond_true = !v;
				4'h9: cond_true = v;
				4'ha: cond_true = !n;
				4'hb: cond_true = n;
				4'hc: cond_true = !(n ^ v);
				4'hd: cond_true = n ^ v;
				4'he: cond_true = !(z | (n ^ v));
				default: cond_true = z | (n ^ v);
			endcase
		end
	endfunction

	// Changes one bit of a byte read back from memory.
	function [7:0] bit_modify;
		input [7:0] d;
		input [3:0] op_sel;
		input [2:0] pos;
		input c;
		reg [7:0] m;
		begin
			m = 8'h01 << pos;
			case (op_sel)
				`CSX_BIT_SET: bit_modify = d | m;
				`CSX_BIT_CLR: bit_modify = d & ~m;
				`CSX_BIT_NOT: bit_modify = d ^ m;
				`CSX_BIT_ST: bit_modify = c ? (d | m) : (d & ~m);
				`CSX_BIT_IST: bit_modify = c ? (d & ~m) : (d | m);
				default: bit_modify = d;
			endcase
		end
	endfunction

	// =========================================================
	// Wake pin synchroniser
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else begin
			wake_meta <= wake_pin;
			wake_sync <= wake_meta;
		end
	end

	// =========================================================
	// Next values of the block-move registers
	wire [CNT_W-1:0] next_count = bm_byte ?
		{count[CNT_W-1:8], count[7:0] - 8'h01} : count - {{(CNT_W-1){1'b0}}, 1'b1};
	wire next_count_zero = bm_byte ? (next_count[7:0] == 8'h00) :
		(next_count == {CNT_W{1'b0}});
	wire [PTR_W-1:0] next_src = src_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
	wire [PTR_W-1:0] next_dst = dst_ptr + {{(PTR_W-1){1'b0}}, 1'b1};

	// =========================================================
	// Execution engine
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			flags <= `CSX_FLAGS_RST;
			count <= {CNT_W{1'b0}};
			src_ptr <= {PTR_W{1'b0}};
			dst_ptr <= {PTR_W{1'b0}};
			bm_byte <= 1'b0;
			bit_sub <= 4'h0;
			bit_no <= 3'h0;
			pc_adv <= 1'b0;
			pc_step <= 4'h0;
			trap_start <= 1'b0;
			trap_vector <= 2'h0;
			rte_start <= 1'b0;
			sleep_mode <= 1'b0;
			branch_taken <= 1'b0;
			branch_disp <= 8'h00;
			addr_reg_sel <= 3'h0;
			data_reg_sel <= 4'h0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_word <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 16'h0000;
		end else begin
			pc_adv <= 1'b0;
			trap_start <= 1'b0;
			rte_start <= 1'b0;
			branch_taken <= 1'b0;
			if (sleep_mode && wake_sync)
				sleep_mode <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (reg_wr) begin
						case (reg_addr)
							`CSX_REG_FLAGS: flags <= reg_wdata[7:0];
							`CSX_REG_COUNT: count <= reg_wdata[CNT_W-1:0];
							`CSX_REG_SRC: src_ptr <= reg_wdata[PTR_W-1:0];
							`CSX_REG_DST: dst_ptr <= reg_wdata[PTR_W-1:0];
							default: ;
						endcase
					end
					if (take) begin
						pc_adv <= 1'b1;
						pc_step <= ins_len(op, sub);
						addr_reg_sel <= ins_word[`CSX_F_AREG];
						data_reg_sel <= ins_word[`CSX_F_DREG];
						mem_addr <= ext_addr(ins_ext);
						bit_sub <= sub;
						bit_no <= ins_word[`CSX_F_BITNO];
						case (op)
							`CSX_OP_SYS: begin
								case (sub)
									`CSX_SYS_SLEEP: sleep_mode <= 1'b1;
									`CSX_SYS_RTE: rte_start <= 1'b1;
									`CSX_SYS_TRAP: begin
										trap_start <= 1'b1;
										trap_vector <= ins_word[`CSX_F_TRAP];
									end
									`CSX_SYS_AND_FLAGS_IMM: flags <= flags & imm;
									`CSX_SYS_ORC: flags <= flags | imm;
									`CSX_SYS_XOR_FLAGS_IMM: flags <= flags ^ imm;
									`CSX_SYS_LDF: begin
										mem_req <= 1'b1;
										mem_we <= 1'b0;
										mem_word <= 1'b1;
										state <= ST_LDF;
									end
									`CSX_SYS_STF: begin
										mem_req <= 1'b1;
										mem_we <= 1'b1;
										mem_word <= 1'b1;
										mem_wdata <= {flags, flags};
										state <= ST_STF;
									end
									`CSX_SYS_BMB, `CSX_SYS_BMW: begin
										bm_byte <= (sub == `CSX_SYS_BMB);
										if ((sub == `CSX_SYS_BMB) ?
											(count[7:0] != 8'h00) :
											(count != {CNT_W{1'b0}})) begin
											mem_req <= 1'b1;
											mem_we <= 1'b0;
											mem_word <= 1'b0;
											mem_addr <= src_ptr[23:0];
											state <= ST_BM_RD;
										end
									end
									default: ;
								endcase
							end
							`CSX_OP_BRANCH: begin
								branch_taken <= cond_true(ins_word[`CSX_F_CC], flags);
								branch_disp <= imm;
							end
							`CSX_OP_BIT: begin
								mem_req <= 1'b1;
								mem_we <= 1'b0;
								mem_word <= 1'b0;
								state <= ST_RMW_RD;
							end
							default: ;
						endcase
					end
				end
				ST_LDF: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						flags <= mem_rdata[15:8];
						state <= ST_IDLE;
					end
				end
				ST_STF: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_BM_RD: begin
					if (mem_ack) begin
						src_ptr <= next_src;
						mem_we <= 1'b1;
						mem_addr <= dst_ptr[23:0];
						mem_wdata <= {8'h00, mem_rdata[7:0]};
						state <= ST_BM_WR;
					end
				end
				ST_BM_WR: begin
					if (mem_ack) begin
						dst_ptr <= next_dst;
						count <= next_count;
						mem_we <= 1'b0;
						if (next_count_zero) begin
							mem_req <= 1'b0;
							state <= ST_IDLE;
						end else begin
							// The source pointer already moved on after the read.
							mem_addr <= src_ptr[23:0];
							state <= ST_BM_RD;
						end
					end
				end
				ST_RMW_RD: begin
					if (mem_ack) begin
						mem_we <= 1'b1;
						mem_wdata <= {8'h00, bit_modify(mem_rdata[7:0], bit_sub, bit_no,
							flags[`CSX_FL_C])};
						state <= ST_RMW_WR;
					end
				end
				ST_RMW_WR: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// =========================================================
	// Register read port
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`CSX_REG_FLAGS: reg_rdata <= {24'h000000, flags};
				`CSX_REG_COUNT: reg_rdata <= {{(32-CNT_W){1'b0}}, count};
				`CSX_REG_SRC: reg_rdata <= src_ptr;
				`CSX_REG_DST: reg_rdata <= dst_ptr;
				`CSX_REG_STATUS: reg_rdata <= {24'h000000, bm_byte, state, trap_vector,
					sleep_mode, busy};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// ---- verification/csx_exec_properties.sv ----
// Concurrent checks on the ports of the system-control executor.
`timescale 1ns/10ps
module csx_exec_chk (
	input wire sys_clk,
	input wire rst_n,
	input wire ins_valid,
	input wire ins_ready,
	input wire [15:0] ins_word,
	input wire [3:0] pc_step,
	input wire trap_start,
	input wire [1:0] trap_vector,
	input wire rte_start,
	input wire sleep_mode,
	input wire mem_req,
	input wire mem_we,
	input wire mem_word,
	input wire [7:0] condition_flags_reg,
	input wire busy
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	wire t = ins_valid && ins_ready;
	wire [7:0] c = ins_word[15:8];
	wire [7:0] f = condition_flags_reg;
	a_nop_step_only: assert property (t && c == 8'h00 |=> pc_step == 4'h2 && $stable(f))
		else $error("nop changed more than the pc");
	a_and_flags: assert property (t && c == 8'h04 |=> f == ($past(f) & $past(ins_word[7:0])))
		else $error("and with flags wrong");
	a_or_flags: assert property (t && c == 8'h05 |=> f == ($past(f) | $past(ins_word[7:0])))
		else $error("or with flags wrong");
	a_xor_flags: assert property (t && c == 8'h06 |=> f == ($past(f) ^ $past(ins_word[7:0])))
		else $error("xor with flags wrong");
	a_trap_vector: assert property (t && c == 8'h03 |=> trap_start && trap_vector == $past(ins_word[5:4]))
		else $error("trap start or vector wrong");
	a_return_pulse: assert property (t && c == 8'h02 |=> rte_start)
		else $error("return did not start");
	a_sleep_entry: assert property (t && c == 8'h01 |=> sleep_mode && !ins_ready)
		else $error("sleep not entered");
	a_flags_word: assert property (t && (c == 8'h07 || c == 8'h08) |=> mem_req && mem_word && mem_we == $past(ins_word[11]))
		else $error("flags access not a word access");
	a_busy_refuse: assert property (busy |-> !ins_ready)
		else $error("instruction accepted while busy");
endmodule
bind csx_exec csx_exec_chk u_csx_exec_chk (.sys_clk, .rst_n, .ins_valid, .ins_ready, .ins_word,
	.pc_step, .trap_start, .trap_vector, .rte_start, .sleep_mode, .mem_req, .mem_we, .mem_word,
	.condition_flags_reg, .busy);

// ---- verification/csx_mem_model.sv ----
// Memory partner answering the executor after a settable number of wait cycles.
`timescale 1ns/10ps
module csx_mem_model (
	input wire sys_clk,
	input wire rst_n,
	input wire mem_req,
	input wire mem_we,
	input wire mem_word,
	input wire [23:0] mem_addr,
	input wire [15:0] mem_wdata,
	input wire [3:0] slow,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [0:1023];
	logic [3:0] waited;
	wire [9:0] a = mem_addr[9:0];
	initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5a;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			waited <= 4'h0;
			mem_rdata <= 16'h0000;
		end else if (mem_req && !mem_ack && waited >= slow) begin
			mem_ack <= 1'b1;
			waited <= 4'h0;
			mem_rdata <= mem_word ? {mem[a], mem[a + 10'h1]} : {~mem[a], mem[a]};
			if (mem_we)
				mem[a] <= mem_word ? mem_wdata[15:8] : mem_wdata[7:0];
			if (mem_we && mem_word)
				mem[a + 10'h1] <= mem_wdata[7:0];
		end else begin
			// Between answers the read lines toggle, inverting the last data every cycle.
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			waited <= mem_req && !mem_ack ? waited + 4'h1 : 4'h0;
		end
	end
endmodule

// ---- verification/csx_exec_tb.sv ----
// Self-checking testbench for the system-control executor.
`timescale 1ns/10ps
`include "csx_map.vh"
module csx_exec_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, ins_valid = 1'b0, wake_pin = 1'b0, reg_wr = 1'b0;
	logic reg_rd = 1'b0, ins_ready, pc_adv, trap_start, rte_start, sleep_mode, branch_taken;
	logic mem_req, mem_we, mem_word, mem_ack, busy;
	logic [1:0] trap_vector;
	logic [2:0] reg_addr = 3'h0, addr_reg_sel;
	logic [3:0] slow = 4'h0, pc_step, data_reg_sel;
	logic [7:0] branch_disp, condition_flags_reg, fl = 8'h80, g, m, e;
	logic [7:0] imm [0:2];
	logic [15:0] ins_word = 16'h0000, mem_wdata, mem_rdata;
	logic [23:0] mem_addr;
	logic [31:0] ins_ext = 32'h0, reg_wdata = 32'h0, reg_rdata, d;
	int checks = 0, n_mismatch = 0;
	always #5 sys_clk = ~sys_clk;
	csx_exec u_csx_exec (.sys_clk, .rst_n, .ins_valid, .ins_ready, .ins_word, .ins_ext, .pc_adv,
		.pc_step, .trap_start, .trap_vector, .rte_start, .sleep_mode, .wake_pin, .branch_taken,
		.branch_disp, .addr_reg_sel, .data_reg_sel, .mem_req, .mem_we, .mem_word, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.condition_flags_reg, .busy);
	csx_mem_model u_csx_mem_model (.sys_clk, .rst_n, .mem_req, .mem_we, .mem_word, .mem_addr,
		.mem_wdata, .slow, .mem_rdata, .mem_ack);
	function logic [7:0] init(input logic [9:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	task chk(input string what, input logic [31:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task issue(input logic [15:0] w, input logic [31:0] x);
		ins_word <= w;
		ins_ext <= x;
		ins_valid <= 1'b1;
		@(posedge sys_clk);
		for (int n = 0; n < 3000 && ins_ready !== 1'b1; n++)
			@(posedge sys_clk);
		chk("ready wait", 32'h1, {31'h0, ins_ready});
		ins_valid <= 1'b0;
	endtask
	task settle();
		@(posedge sys_clk);
		for (int n = 0; n < 3000 && busy !== 1'b0; n++)
			@(posedge sys_clk);
		chk("idle wait", 32'h0, {31'h0, busy});
	endtask
	task reg_op(input logic wr, input logic [2:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
	task t_flags();
		imm = '{8'h5c, 8'h21, 8'hfe};
		issue(16'h0000, 32'h0);
		@(posedge sys_clk);
		chk("nop", {1'b1, 4'h2, fl}, {pc_adv, pc_step, condition_flags_reg});
		for (int i = 0; i < 3; i++) begin
			issue({8'h04 + i[7:0], imm[i]}, 32'h0);
			@(posedge sys_clk);
			fl = i == 0 ? fl & imm[i] : i == 1 ? fl | imm[i] : fl ^ imm[i];
			chk("flags", fl, condition_flags_reg);
			chk("regsel", imm[i][6:0], {addr_reg_sel, data_reg_sel});
		end
		$display("flag logic test done");
	endtask
	task t_branch();
		for (int c = 0; c < 16; c++) begin
			issue({4'h4, c[3:0], 8'h3c}, 32'h0);
			@(posedge sys_clk);
			g = {fl[2] | (fl[3] ^ fl[1]), fl[3] ^ fl[1], fl[3], fl[1], fl[2], fl[0], fl[0] | fl[2], 1'b0};
			chk("branch", {g[c[3:1]] ^ ~c[0], 8'h3c}, {branch_taken, branch_disp});
		end
		$display("branch test done");
	endtask
	task t_trap();
		for (int v = 0; v < 4; v++) begin
			issue({8'h03, 2'b00, v[1:0], 4'h0}, 32'h0);
			@(posedge sys_clk);
			chk("trap", {1'b1, v[1:0]}, {trap_start, trap_vector});
		end
		issue(16'h0200, 32'h0);
		@(posedge sys_clk);
		chk("return", 2'b10, {rte_start, trap_start});
		issue(16'h0100, 32'h0);
		@(posedge sys_clk);
		chk("sleep", 2'b10, {sleep_mode, ins_ready});
		wake_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("wake", 2'b01, {sleep_mode, ins_ready});
		wake_pin <= 1'b0;
		$display("trap return sleep test done");
	endtask
	task t_bits();
		for (int s = 0; s < 5; s++) begin
			issue({4'h7, s[3:0], 8'h30}, {22'h0, 10'h060} + s);
			@(posedge sys_clk);
			chk("bit step", 4'h6, pc_step);
			settle();
			m = init(10'h060 + s[9:0]);
			e = s == 1 || (s == 3 && !fl[0]) || (s == 4 && fl[0]) ? m & 8'hf7 : m | 8'h08;
			chk("bit byte", s == 2 ? m ^ 8'h08 : e, u_csx_mem_model.mem[10'h060 + s[9:0]]);
		end
		$display("bit rewrite test done");
	endtask
	task t_ldst();
		issue(16'h0800, 32'h00000040);
		@(posedge sys_clk);
		chk("store step", 4'h6, pc_step);
		settle();
		chk("store", {fl, fl}, {u_csx_mem_model.mem[10'h040], u_csx_mem_model.mem[10'h041]});
		slow <= 4'h3;
		issue(16'h0700, 32'h00000050);
		settle();
		fl = init(10'h050);
		chk("load", fl, condition_flags_reg);
		reg_op(1'b0, `CSX_REG_FLAGS, 32'h0);
		chk("flags reg", {24'h0, fl}, d);
		reg_op(1'b0, 3'h7, 32'h0);
		chk("unmapped", 32'h0, d);
		reg_op(1'b0, `CSX_REG_STATUS, 32'h0);
		chk("status", 32'h0000000c, d);
		slow <= 4'h0;
		$display("flags load store test done");
	endtask
	task bm(input logic [7:0] op, input logic [15:0] cnt, input logic [9:0] s, t, input int n);
		reg_op(1'b1, `CSX_REG_COUNT, {16'h0, cnt});
		reg_op(1'b1, `CSX_REG_SRC, {22'h0, s});
		reg_op(1'b1, `CSX_REG_DST, {22'h0, t});
		issue({op, 8'h00}, 32'h0);
		@(posedge sys_clk);
		issue(16'h0000, 32'h0);
		for (int i = 0; i <= n; i++)
			chk("moved", init(i < n ? s + i[9:0] : t + i[9:0]), u_csx_mem_model.mem[t + i[9:0]]);
		reg_op(1'b0, `CSX_REG_COUNT, 32'h0);
		chk("count", op == 8'h09 ? {16'h0, cnt[15:8], 8'h00} : 32'h0, d);
		reg_op(1'b0, `CSX_REG_SRC, 32'h0);
		chk("src", {22'h0, s} + n, d);
		reg_op(1'b0, `CSX_REG_DST, 32'h0);
		chk("dst", {22'h0, t} + n, d);
		$display("block move test done");
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		n_mismatch++;
		$display("watchdog expired");
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_flags();
		t_branch();
		t_trap();
		t_bits();
		t_ldst();
		t_branch();
		bm(8'h09, 16'h0103, 10'h010, 10'h080, 3);
		bm(8'h09, 16'h0100, 10'h010, 10'h0a0, 0);
		bm(8'h0a, 16'h0101, 10'h100, 10'h280, 257);
		print_verdict();
	end
endmodule
